// ===== pkg/pmon_pkg.sv
/*
 * Shared constants and types of the power monitor result and limit logic.
 * Assumes one reference clock and one link sampling clock around the core.
 */
package pmon_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int REF_CLK_MHZ = 50;
  localparam int CONV_T0_US = 50;
  localparam int CONV_T1_US = 84;
  localparam int CONV_T2_US = 150;
  localparam int CONV_T3_US = 280;
  localparam int CONV_T4_US = 540;
  localparam int CONV_T5_US = 1052;
  localparam int CONV_T6_US = 2074;
  localparam int CONV_T7_US = 4120;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_ADC_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_BUS_V = 8'h05;
  localparam logic [7:0] ADDR_DIE_TEMP = 8'h06;
  localparam logic [7:0] ADDR_CURRENT = 8'h07;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_ENERGY = 8'h09;
  localparam logic [7:0] ADDR_CHARGE = 8'h0A;
  localparam logic [7:0] ADDR_DIAG = 8'h0B;
  localparam logic [7:0] ADDR_TEMP_THR = 8'h10;
  localparam logic [7:0] ADDR_PWR_THR = 8'h11;
  localparam logic [7:0] ADDR_MAKER = 8'h3E;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_ACCUMULATOR_RESET_BIT_BIT = 14;
  localparam int ADC_CT_LSB = 6;
  localparam int ADC_AVG_LSB = 0;
  localparam int DIAG_ALERT_LATCH_ENABLE_BIT = 15;
  localparam int DIAG_CHARGE_OVERFLOW_FLAG_BIT = 10;
  localparam int DIAG_OVERTEMP_STATUS_FLAG_BIT = 7;
  localparam int DIAG_POL_BIT = 2;
  localparam int POWER_SHIFT = 14;

  // ****************************************************************
  // reset values and identity
  // ****************************************************************
  localparam logic [15:0] TEMP_THR_RST = 16'h7FFF;
  localparam logic [15:0] PWR_THR_RST = 16'hFFFF;
  localparam logic [15:0] ADC_CONFIG_RST = 16'h0000;
  localparam logic [15:0] MAKER_ID_DEFAULT = 16'h5A5A; // arbitrary value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [19:0] current;
    logic [19:0] bus_v;
    logic [15:0] die_temp;
  } pmon_sample_t;

  typedef struct packed {
    logic over_temp;
    logic over_power;
    logic charge_overflow;
    logic result_ready;
  } pmon_status_t;

  typedef enum {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_PTR, LK_PTR_ACK,
    LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RDATA_ACK
  } pmon_link_state_t;

endpackage

// ===== core/pmon_core.sv
/*
 * Result, accumulator and limit register logic of a power monitor,
 * reached over a two-wire serial link sampled by its own clock.
 * Assumes the front end presents a fresh raw sample at every
 * conversion tick, on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) temperature limit is signed, same scale as the die temperature result
// (R2) die temperature compared with its limit after each sample
// (R3) power result compared with the 16-bit power limit
// (R4) power limit unsigned, matched against power result bits 23..8
// (R5) read-only 16-bit maker identity register
// (R6) current result: 20-bit signed at 7h
// (R7) bus voltage result: 20-bit signed, non-negative, at 5h
// (R8) bus voltage encoding spans 102.4 V, valid range only 40 V
// (R9) die temperature: 16-bit signed at 6h
// (R10) signed values in two's complement
// (R11) energy accumulator wraps at 40 bits with no flag
// (R12) accumulator reset bit clears energy at any time
// (R13) charge accumulator overflow sets the charge overflow flag
// (R14) host must clear charge overflow with the accumulator reset bit
// (R15) eight conversion times from 50 to 4120 microseconds
// (R16) shortest conversion time is 50 microseconds
// (R17) averaging count selectable; sample period is time times count
// (R18) overtemperature flag, cleared by status read when latching
// (R19) power flag set when power exceeds its limit
// (R20) charge overflow flag cleared only by accumulator reset
// (R21) power 24-bit at 8h, energy and charge 40-bit at 9h, Ah
// (R22) limit checks once per averaged sample with fresh results
module pmon_core #(
  parameter int TICKS_PER_US = pmon_pkg::REF_CLK_MHZ,
  parameter logic [15:0] MAKER_ID = pmon_pkg::MAKER_ID_DEFAULT,
  parameter logic [6:0] DEV_ADDR = pmon_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire pmon_pkg::pmon_sample_t front_sample,
  output logic conv_tick,
  output pmon_pkg::pmon_status_t status
);

  // ****************************************************************
  // link side: synchronisers
  // ****************************************************************
  logic link_rst_s1, link_rst;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic ack_s1, ack_s2, ack_d;
  logic ack_tog_reg;
  logic [39:0] rdata_reg;

  always_ff @(posedge link_clk) begin
    link_rst_s1 <= reset;
    link_rst <= link_rst_s1;
  end

  always_ff @(posedge link_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    ack_s1 <= ack_tog_reg;
    ack_s2 <= ack_s1;
    ack_d <= ack_s2;
  end

  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign sda_out = 1'b0;

  // ****************************************************************
  // link side: serial slave
  // ****************************************************************
  pmon_pkg::pmon_link_state_t st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg, ptr_reg;
  logic [15:0] wbuf_reg;
  logic [39:0] tx_reg, rx_word_reg;
  logic rw_reg, byte_idx_reg, nack_reg, sda_oe_reg, req_tog_reg, req_write_reg;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_word_reg <= 40'h0000000000;
    end else if (ack_s2 != ack_d) begin
      rx_word_reg <= rdata_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      st_reg <= pmon_pkg::LK_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wbuf_reg <= 16'h0000;
      tx_reg <= 40'h0000000000;
      rw_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      req_tog_reg <= 1'b0;
      req_write_reg <= 1'b0;
    end else if (start_ev) begin
      st_reg <= pmon_pkg::LK_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= pmon_pkg::LK_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (scl_rise) begin
      if (st_reg == pmon_pkg::LK_RDATA_ACK) begin
        nack_reg <= sda_s2;
      end else begin
        sh_reg <= {sh_reg[6:0], sda_s2};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (st_reg)
        pmon_pkg::LK_ADDR: begin
          if (bit_cnt_reg == 4'h8) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              sda_oe_reg <= 1'b1;
              rw_reg <= sh_reg[0];
              st_reg <= pmon_pkg::LK_ADDR_ACK;
              if (sh_reg[0]) begin
                req_write_reg <= 1'b0;
                req_tog_reg <= ~req_tog_reg;
              end
            end else begin
              st_reg <= pmon_pkg::LK_IDLE;
            end
          end
        end
        pmon_pkg::LK_ADDR_ACK: begin
          bit_cnt_reg <= 4'h0;
          byte_idx_reg <= 1'b0;
          if (rw_reg) begin
            sda_oe_reg <= ~rx_word_reg[39];
            tx_reg <= {rx_word_reg[38:0], 1'b0};
            st_reg <= pmon_pkg::LK_RDATA;
          end else begin
            sda_oe_reg <= 1'b0;
            st_reg <= pmon_pkg::LK_PTR;
          end
        end
        pmon_pkg::LK_PTR: begin
          if (bit_cnt_reg == 4'h8) begin
            ptr_reg <= sh_reg;
            sda_oe_reg <= 1'b1;
            st_reg <= pmon_pkg::LK_PTR_ACK;
          end
        end
        pmon_pkg::LK_WDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            wbuf_reg <= {wbuf_reg[7:0], sh_reg};
            sda_oe_reg <= 1'b1;
            st_reg <= pmon_pkg::LK_WDATA_ACK;
            if (byte_idx_reg) begin
              req_write_reg <= 1'b1;
              req_tog_reg <= ~req_tog_reg;
            end
            byte_idx_reg <= ~byte_idx_reg;
          end
        end
        pmon_pkg::LK_PTR_ACK, pmon_pkg::LK_WDATA_ACK: begin
          sda_oe_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
          st_reg <= pmon_pkg::LK_WDATA;
        end
        pmon_pkg::LK_RDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            sda_oe_reg <= 1'b0;
            st_reg <= pmon_pkg::LK_RDATA_ACK;
          end else begin
            sda_oe_reg <= ~tx_reg[39];
            tx_reg <= {tx_reg[38:0], 1'b0};
          end
        end
        pmon_pkg::LK_RDATA_ACK: begin
          if (nack_reg) begin
            sda_oe_reg <= 1'b0;
            st_reg <= pmon_pkg::LK_IDLE;
          end else begin
            sda_oe_reg <= ~tx_reg[39];
            tx_reg <= {tx_reg[38:0], 1'b0};
            bit_cnt_reg <= 4'h0;
            st_reg <= pmon_pkg::LK_RDATA;
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_oe = sda_oe_reg;

  // ****************************************************************
  // core side: request handshake and register writes
  // ****************************************************************
  logic req_s1, req_s2, req_d, req_event, wr_en, rd_diag;
  logic [15:0] temp_thr_reg, pwr_thr_reg, adc_cfg_reg;
  logic alert_latch_enable_reg, accumulator_reset_bit_reg;

  always_ff @(posedge ref_clk) begin
    req_s1 <= req_tog_reg;
    req_s2 <= req_s1;
    req_d <= req_s2;
  end

  assign req_event = req_s2 ^ req_d;
  assign wr_en = req_event & req_write_reg;
  assign rd_diag = req_event & ~req_write_reg & (ptr_reg == pmon_pkg::ADDR_DIAG);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      temp_thr_reg <= pmon_pkg::TEMP_THR_RST;
      pwr_thr_reg <= pmon_pkg::PWR_THR_RST;
      adc_cfg_reg <= pmon_pkg::ADC_CONFIG_RST;
      alert_latch_enable_reg <= 1'b0;
      accumulator_reset_bit_reg <= 1'b0;
    end else begin
      accumulator_reset_bit_reg <= 1'b0;
      if (wr_en) begin
        case (ptr_reg)
          pmon_pkg::ADDR_CONFIG: accumulator_reset_bit_reg <= wbuf_reg[pmon_pkg::CFG_ACCUMULATOR_RESET_BIT_BIT]; // see (R12)
          pmon_pkg::ADDR_ADC_CONFIG: adc_cfg_reg <= wbuf_reg;
          pmon_pkg::ADDR_DIAG: alert_latch_enable_reg <= wbuf_reg[pmon_pkg::DIAG_ALERT_LATCH_ENABLE_BIT];
          pmon_pkg::ADDR_TEMP_THR: temp_thr_reg <= wbuf_reg; // see (R1)
          pmon_pkg::ADDR_PWR_THR: pwr_thr_reg <= wbuf_reg; // see (R4)
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // core side: conversion timer
  // ****************************************************************
  logic [2:0] ct_sel, avg_sel;
  logic [12:0] conv_us, us_reg;
  logic [7:0] pre_reg;
  logic [3:0] avg_shift;
  logic [9:0] avg_mask;
  logic tick_reg;

  assign ct_sel = adc_cfg_reg[pmon_pkg::ADC_CT_LSB +: 3];
  assign avg_sel = adc_cfg_reg[pmon_pkg::ADC_AVG_LSB +: 3];

  always_comb begin
    case (ct_sel) // see (R15) (R16)
      3'h0: conv_us = 13'(pmon_pkg::CONV_T0_US);
      3'h1: conv_us = 13'(pmon_pkg::CONV_T1_US);
      3'h2: conv_us = 13'(pmon_pkg::CONV_T2_US);
      3'h3: conv_us = 13'(pmon_pkg::CONV_T3_US);
      3'h4: conv_us = 13'(pmon_pkg::CONV_T4_US);
      3'h5: conv_us = 13'(pmon_pkg::CONV_T5_US);
      3'h6: conv_us = 13'(pmon_pkg::CONV_T6_US);
      default: conv_us = 13'(pmon_pkg::CONV_T7_US);
    endcase
    case (avg_sel) // see (R17)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
    avg_mask = 10'((11'h001 << avg_shift) - 11'h001);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_reg <= 8'h00;
      us_reg <= 13'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (pre_reg == 8'(TICKS_PER_US - 1)) begin
        pre_reg <= 8'h00;
        if (us_reg >= conv_us - 13'h0001) begin
          us_reg <= 13'h0000;
          tick_reg <= 1'b1;
        end else begin
          us_reg <= us_reg + 13'h0001;
        end
      end else begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end

  assign conv_tick = tick_reg;

  // ****************************************************************
  // core side: averaging and results
  // ****************************************************************
  logic signed [29:0] cur_sum_reg, vbus_sum_reg, cur_tot, vbus_tot, cur_avg, vbus_avg;
  logic signed [25:0] temp_sum_reg, temp_tot, temp_avg;
  logic [9:0] avg_cnt_reg;
  logic [19:0] cur_reg, vbus_reg;
  logic [15:0] temp_reg;
  logic avg_done_reg, pwr_done_reg, ready_reg;

  assign cur_tot = cur_sum_reg + {{10{front_sample.current[19]}}, front_sample.current}; // see (R10)
  assign vbus_tot = vbus_sum_reg + {{10{front_sample.bus_v[19]}}, front_sample.bus_v};
  assign temp_tot = temp_sum_reg + {{10{front_sample.die_temp[15]}}, front_sample.die_temp};
  assign cur_avg = cur_tot >>> avg_shift;
  assign vbus_avg = vbus_tot >>> avg_shift;
  assign temp_avg = temp_tot >>> avg_shift;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_sum_reg <= '0;
      vbus_sum_reg <= '0;
      temp_sum_reg <= '0;
      avg_cnt_reg <= 10'h000;
      cur_reg <= 20'h00000;
      vbus_reg <= 20'h00000;
      temp_reg <= 16'h0000;
      avg_done_reg <= 1'b0;
    end else begin
      avg_done_reg <= 1'b0;
      if (tick_reg) begin
        if (avg_cnt_reg >= avg_mask) begin
          cur_sum_reg <= '0;
          vbus_sum_reg <= '0;
          temp_sum_reg <= '0;
          avg_cnt_reg <= 10'h000;
          cur_reg <= cur_avg[19:0]; // see (R6)
          vbus_reg <= vbus_avg[19] ? 20'h00000 : vbus_avg[19:0]; // see (R7) (R8)
          temp_reg <= temp_avg[15:0]; // see (R9)
          avg_done_reg <= 1'b1;
        end else begin
          cur_sum_reg <= cur_tot;
          vbus_sum_reg <= vbus_tot;
          temp_sum_reg <= temp_tot;
          avg_cnt_reg <= avg_cnt_reg + 10'h001;
        end
      end
    end
  end

  // ****************************************************************
  // core side: power, energy, charge
  // ****************************************************************
  logic [19:0] cur_mag;
  logic [39:0] prod;
  logic [23:0] pwr_reg;
  logic [39:0] energy_reg, charge_reg;
  logic [40:0] charge_sum;
  logic chg_of_reg;

  assign cur_mag = cur_reg[19] ? (~cur_reg + 20'h00001) : cur_reg;
  assign prod = {20'h00000, cur_mag} * {20'h00000, vbus_reg};
  assign charge_sum = {1'b0, charge_reg} + {21'h000000, cur_mag};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwr_reg <= 24'h000000;
      pwr_done_reg <= 1'b0;
    end else begin
      pwr_done_reg <= avg_done_reg;
      if (avg_done_reg) begin
        pwr_reg <= (|prod[39:38]) ? 24'hFFFFFF : prod[pmon_pkg::POWER_SHIFT +: 24]; // see (R21)
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || accumulator_reset_bit_reg) begin
      energy_reg <= 40'h0000000000; // see (R12)
      charge_reg <= 40'h0000000000;
    end else begin
      if (pwr_done_reg) begin
        energy_reg <= energy_reg + {16'h0000, pwr_reg}; // see (R11)
      end
      if (avg_done_reg) begin
        charge_reg <= charge_sum[39:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chg_of_reg <= 1'b0;
    end else if (avg_done_reg && charge_sum[40]) begin
      chg_of_reg <= 1'b1; // see (R13)
    end else if (accumulator_reset_bit_reg) begin
      chg_of_reg <= 1'b0; // see (R14) (R20)
    end
  end

  // ****************************************************************
  // core side: limit checks and flags
  // ****************************************************************
  logic temp_over, pwr_over, overtemp_status_flag_reg, pol_reg;

  assign temp_over = $signed(temp_reg) > $signed(temp_thr_reg); // see (R1) (R2)
  assign pwr_over = pwr_reg[23:8] > pwr_thr_reg; // see (R3) (R4)

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overtemp_status_flag_reg <= 1'b0;
      pol_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= pwr_done_reg;
      if (pwr_done_reg && (temp_over || !alert_latch_enable_reg)) begin
        overtemp_status_flag_reg <= temp_over; // see (R18) (R22)
      end else if (rd_diag && alert_latch_enable_reg) begin
        overtemp_status_flag_reg <= 1'b0;
      end
      if (pwr_done_reg && (pwr_over || !alert_latch_enable_reg)) begin
        pol_reg <= pwr_over; // see (R19) (R22)
      end else if (rd_diag && alert_latch_enable_reg) begin
        pol_reg <= 1'b0;
      end
    end
  end

  assign status = '{over_temp: overtemp_status_flag_reg, over_power: pol_reg,
                    charge_overflow: chg_of_reg, result_ready: ready_reg};

  // ****************************************************************
  // core side: read data, left aligned by byte count
  // ****************************************************************
  logic [15:0] diag_word;

  always_comb begin
    diag_word = 16'h0000;
    diag_word[pmon_pkg::DIAG_ALERT_LATCH_ENABLE_BIT] = alert_latch_enable_reg;
    diag_word[pmon_pkg::DIAG_CHARGE_OVERFLOW_FLAG_BIT] = chg_of_reg;
    diag_word[pmon_pkg::DIAG_OVERTEMP_STATUS_FLAG_BIT] = overtemp_status_flag_reg;
    diag_word[pmon_pkg::DIAG_POL_BIT] = pol_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 40'h0000000000;
      ack_tog_reg <= 1'b0;
    end else if (req_event) begin
      ack_tog_reg <= ~ack_tog_reg;
      if (!req_write_reg) begin
        case (ptr_reg)
          pmon_pkg::ADDR_ADC_CONFIG: rdata_reg <= {adc_cfg_reg, 24'h000000};
          pmon_pkg::ADDR_BUS_V: rdata_reg <= {vbus_reg, 20'h00000};
          pmon_pkg::ADDR_DIE_TEMP: rdata_reg <= {temp_reg, 24'h000000};
          pmon_pkg::ADDR_CURRENT: rdata_reg <= {cur_reg, 20'h00000};
          pmon_pkg::ADDR_POWER: rdata_reg <= {pwr_reg, 16'h0000};
          pmon_pkg::ADDR_ENERGY: rdata_reg <= energy_reg;
          pmon_pkg::ADDR_CHARGE: rdata_reg <= charge_reg;
          pmon_pkg::ADDR_DIAG: rdata_reg <= {diag_word, 24'h000000};
          pmon_pkg::ADDR_TEMP_THR: rdata_reg <= {temp_thr_reg, 24'h000000};
          pmon_pkg::ADDR_PWR_THR: rdata_reg <= {pwr_thr_reg, 24'h000000};
          pmon_pkg::ADDR_MAKER: rdata_reg <= {MAKER_ID, 24'h000000}; // see (R5)
          default: rdata_reg <= 40'h0000000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/pmon_chk.sv
/* assertion checker on the ports of the monitor core.
   assumes it is bound to each pmon_core instance. */
`timescale 1ns/1ps
`default_nettype none
module pmon_chk #(
  parameter int TICKS_PER_US = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic conv_tick,
  input wire pmon_pkg::pmon_status_t status
);
  // ****
  // tick spacing
  // ****
  int unsigned gap_reg;
  logic seen_reg;
  always_ff @(posedge ref_clk) begin
    if (reset || conv_tick) begin
      gap_reg <= 0;
    end else begin
      gap_reg <= gap_reg + 1;
    end
    seen_reg <= !reset && (seen_reg || conv_tick);
  end
  // ****
  // properties
  // ****
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  min_conv_gap_a: assert property (conv_tick && seen_reg |->
    gap_reg >= 50 * TICKS_PER_US - 1)
    else $error("conversion tick too early");
  tick_pulse_a: assert property (conv_tick |=> !conv_tick)
    else $error("conversion tick longer than one cycle");
  ready_after_tick_a: assert property (status.result_ready |-> $past(conv_tick, 3))
    else $error("result ready not three cycles after tick");
  ready_pulse_a: assert property (status.result_ready |=> !status.result_ready [*8])
    else $error("result ready too close");
  temp_flag_set_a: assert property ($rose(status.over_temp) |-> status.result_ready)
    else $error("temperature flag set outside evaluation");
  pwr_flag_set_a: assert property ($rose(status.over_power) |-> $past(conv_tick, 3))
    else $error("power flag set outside evaluation");
  chg_flag_set_a: assert property ($rose(status.charge_overflow) |-> $past(conv_tick, 2))
    else $error("charge flag set outside update");
  reset_quiet_a: assert property ($past(reset) |-> status == 4'h0 && !conv_tick)
    else $error("outputs active after reset");
endmodule
bind pmon_core pmon_chk #(.TICKS_PER_US(TICKS_PER_US)) i_chk (.ref_clk(ref_clk), .reset(reset),
  .conv_tick(conv_tick), .status(status));
`default_nettype wire

// ===== tb/pmon_host.sv
/* two-wire serial host model for the monitor link.
   assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module pmon_host (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ****
  // bit and frame cycles
  // ****
  localparam int Q = 14;
  localparam logic [7:0] AW = {pmon_pkg::DEV_ADDR_DEFAULT, 1'b0};
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w();
    repeat (Q) @(posedge link_clk);
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !tx[i];
      w();
      scl <= 1'b1;
      w();
      rx[i] = sda;
      w();
      scl <= 1'b0;
      w();
    end
  endtask
  task automatic start();
    sda_low <= 1'b0;
    w();
    scl <= 1'b1;
    w();
    sda_low <= 1'b1;
    w();
    scl <= 1'b0;
    w();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    w();
    scl <= 1'b1;
    w();
    sda_low <= 1'b0;
    repeat (6) w();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic nak);
    logic [7:0] b [4] = '{AW, a, d[15:8], d[7:0]};
    logic [8:0] r;
    nak = 1'b0;
    start();
    for (int i = 0; i < 4; i++) begin
      xfer({b[i], 1'b1}, r);
      nak = nak | r[0];
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n, output logic [39:0] v, output logic nak);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    logic [8:0] r;
    v = '0;
    start();
    xfer({AW, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    start();
    xfer({AW | 8'h01, 1'b1}, r2);
    for (int i = 0; i < n; i++) begin
      xfer({8'hFF, i == n - 1}, r);
      v = {v[31:0], r[8:1]};
    end
    stop();
    nak = r0[0] | r1[0] | r2[0];
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
/* self-checking bench of the monitor core over its serial link.
   assumes the host model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****
  // clocks, wires and instances
  // ****
  localparam logic [15:0] MKR = 16'h3C96; // arbitrary value
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, conv_tick, sda;
  pmon_pkg::pmon_sample_t smp = '0;
  pmon_pkg::pmon_status_t st;
  int error_cnt = 0;
  int checked = 0;
  int tk_ctr = 0, tk_gap = 0, tk_cnt = 0, rd_ctr = 0, rd_gap = 0, rdy_cnt = 0;
  int ct [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  logic [39:0] pw;
  assign sda = !(sda_low | (sda_oe & !sda_out));
  always #10 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  pmon_core #(.TICKS_PER_US(1), .MAKER_ID(MKR)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .front_sample(smp), .conv_tick(conv_tick), .status(st));
  pmon_host i_host (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  always @(posedge ref_clk) begin
    tk_ctr++;
    rd_ctr++;
    if (conv_tick === 1'b1) begin
      tk_gap = tk_ctr;
      tk_ctr = 0;
      tk_cnt++;
    end
    if (st.result_ready === 1'b1) begin
      rd_gap = rd_ctr;
      rd_ctr = 0;
      rdy_cnt++;
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic err(input string m);
    error_cnt++;
    $display("Error %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [39:0] g, input logic [39:0] e);
    checked++;
    if (g !== e) err($sformatf("value %h expected %h", g, e));
  endtask
  task automatic chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) err($sformatf("flag %b expected %b", g, e));
  endtask
  task automatic chk_reg(input logic [7:0] a, input int n, input logic [39:0] e);
    logic [39:0] v;
    logic nk;
    i_host.rd(a, n, v, nk);
    if (nk) err("read not acknowledged");
    chk_val(v, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic nk;
    i_host.wr(a, d, nk);
    if (nk) err("write not acknowledged");
  endtask
  task automatic wait_ev(input bit r, input int k);
    int s;
    int n;
    s = r ? rdy_cnt : tk_cnt;
    n = 0;
    while ((r ? rdy_cnt : tk_cnt) < s + k && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 40000) err("event missing");
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic meas();
    logic [19:0] c;
    logic [19:0] b;
    logic [15:0] t;
    logic [19:0] ac;
    c = 20'($urandom);
    b = 20'($urandom);
    t = 16'($urandom);
    c[18] = ~c[19];
    b[19:18] = 2'b01;
    t[15:14] = {2{t[13]}};
    ac = c[19] ? -c : c;
    pw = ({20'h0, ac} * {20'h0, b}) >> 14;
    if (pw > 40'hFFFFFF) pw = 40'hFFFFFF;
    @(posedge ref_clk);
    smp <= {c, b, t};
    wait_ev(1, 2);
    chk_reg(pmon_pkg::ADDR_CURRENT, 3, {16'h0, c, 4'h0});
    chk_reg(pmon_pkg::ADDR_BUS_V, 3, {16'h0, b, 4'h0});
    chk_reg(pmon_pkg::ADDR_DIE_TEMP, 2, {24'h0, t});
    chk_reg(pmon_pkg::ADDR_POWER, 3, pw);
    wr(pmon_pkg::ADDR_TEMP_THR, t - 16'h1);
    wait_ev(1, 2);
    chk_flag(st.over_temp, 1'b1);
    wr(pmon_pkg::ADDR_TEMP_THR, t);
    wait_ev(1, 2);
    chk_flag(st.over_temp, 1'b0);
    wr(pmon_pkg::ADDR_PWR_THR, pw[23:8] - 16'h1);
    wait_ev(1, 2);
    chk_flag(st.over_power, 1'b1);
    wr(pmon_pkg::ADDR_PWR_THR, pw[23:8]);
    wait_ev(1, 2);
    chk_flag(st.over_power, 1'b0);
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    logic [39:0] v, e;
    logic nk;
    int n0, k;
    void'($urandom(32'h708D));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk_reg(pmon_pkg::ADDR_TEMP_THR, 2, 40'h7FFF);
    chk_reg(pmon_pkg::ADDR_PWR_THR, 2, 40'hFFFF);
    wr(pmon_pkg::ADDR_MAKER, 16'h0000);
    chk_reg(pmon_pkg::ADDR_MAKER, 2, {24'h0, MKR});
    chk_reg(8'h20, 2, 40'h0);
    repeat (2) meas();
    wr(pmon_pkg::ADDR_DIAG, 16'h8000);
    wr(pmon_pkg::ADDR_TEMP_THR, 16'h8000);
    wait_ev(1, 1);
    wr(pmon_pkg::ADDR_TEMP_THR, 16'h7FFF);
    wait_ev(1, 2);
    chk_flag(st.over_temp, 1'b1);
    chk_reg(pmon_pkg::ADDR_DIAG, 2, 40'h8080);
    chk_flag(st.over_temp, 1'b0);
    wr(pmon_pkg::ADDR_ADC_CONFIG, 16'h01C0);
    wait_ev(1, 1);
    n0 = rdy_cnt;
    wr(pmon_pkg::ADDR_CONFIG, 16'h4000);
    i_host.rd(pmon_pkg::ADDR_ENERGY, 5, v, nk);
    k = rdy_cnt - n0;
    e = (k > 0 && v === pw * (k - 1)) ? v : pw * k;
    chk_val(v, e);
    for (int i = 0; i < 8; i++) begin
      wr(pmon_pkg::ADDR_ADC_CONFIG, 16'(i << 6));
      wait_ev(0, 2);
      chk_val(40'(tk_gap), 40'(ct[i]));
    end
    for (int a = 0; a < 3; a++) begin
      wr(pmon_pkg::ADDR_ADC_CONFIG, 16'(a));
      wait_ev(1, 2);
      chk_val(40'(rd_gap), 40'(50 << (2 * a)));
    end
    close_out();
  end
  initial begin
    #2_000_000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
